// >>> inc/lock_pkg.sv
// shared constants for the locked read-modify-write bus sequencer and its partner
`default_nettype none
package lock_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 36;
  localparam int DATA_W = 64;
  localparam int MT_W = 8;
  localparam logic [3:0] LOCK_SPAN_BYTES = 4'h8; // a bus lock is forced past this span
  localparam int RETRY_LIMIT_DEF = 3;

  // ---------------------------------------------------------------
  // memory-type codes carried on attribute_lines
  // ---------------------------------------------------------------
  localparam logic [7:0] MT_UNCACHED = 8'h00;
  localparam logic [7:0] MT_COMBINING_WRITE = 8'h04;
  localparam logic [7:0] MT_WRITE_THROUGH = 8'h05;
  localparam logic [7:0] MT_PROTECTED_WRITE = 8'h06;
  localparam logic [7:0] MT_WRITEBACK = 8'h07;
  localparam logic [7:0] MT_RESET = MT_UNCACHED;

  // ---------------------------------------------------------------
  // response-phase codes
  // ---------------------------------------------------------------
  localparam logic [2:0] RESP_NORMAL = 3'h0;
  localparam logic [2:0] RESP_RETRY = 3'h1;
  localparam logic [2:0] RESP_DEFERRED = 3'h2;
  localparam logic [2:0] RESP_HARD_ERR = 3'h3;
  localparam logic [2:0] RESP_IMPL_WB = 3'h4;

  // ---------------------------------------------------------------
  // phase timing, counted from the first cycle after request clock 2
  // ---------------------------------------------------------------
  localparam logic [2:0] ERR_AT = 3'h1;
  localparam logic [2:0] SNOOP_AT = 3'h2;
  localparam logic [2:0] RESP_AT = 3'h3;
  localparam logic [2:0] ARB_NORM_CLKS = 3'h3; // arbiter count for ordinary agents; the grant follows one clock later, four after request
  localparam logic [2:0] ARB_LEAD_CLKS = 3'h2; // head start of a lock retry
endpackage
`default_nettype wire

// >>> inc/lock_bus_if.sv
// shared system bus between the lock issuer and the other agents
`default_nettype none
interface lock_bus_if;
  import lock_pkg::*;
  logic bus_request_line;
  logic priority_arb;
  logic bus_grant;
  logic req_valid;
  logic req_phase2;
  logic req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [MT_W-1:0] attribute_lines;
  logic [DATA_W-1:0] wdata;
  logic bus_lock_line;
  logic split_lock_flag;
  logic defer_enable_flag;
  logic address_error_signal;
  logic defer_snoop_signal;
  logic hit_issuer;
  logic hit_others;
  logic modified_hit_signal;
  logic [DATA_W-1:0] wb_data;
  logic resp_valid;
  logic [2:0] resp_code;
  logic [DATA_W-1:0] rdata;

  // wired-or of every snooper's modified-hit output
  assign modified_hit_signal = hit_issuer | hit_others;

  modport issuer (
    output bus_request_line, priority_arb, req_valid, req_phase2, req_write, req_addr,
    output attribute_lines, wdata, bus_lock_line, split_lock_flag, defer_enable_flag,
    output hit_issuer, wb_data,
    input bus_grant, address_error_signal, defer_snoop_signal, modified_hit_signal,
    input resp_valid, resp_code, rdata
  );
  modport others (
    input bus_request_line, priority_arb, req_valid, req_phase2, req_write, req_addr,
    input attribute_lines, wdata, bus_lock_line, split_lock_flag, defer_enable_flag,
    input hit_issuer, wb_data, modified_hit_signal,
    output bus_grant, address_error_signal, defer_snoop_signal, hit_others,
    output resp_valid, resp_code, rdata
  );
endinterface
`default_nettype wire

// >>> rtl/lock_others.sv
// the other bus agents: arbiter, memory responder and a modelled foreign cache
`default_nettype none
module lock_others
  import lock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  lock_bus_if.others bus,
  input wire logic inject_address_error_signal,
  input wire logic inject_defer,
  input wire logic inject_modified_hit_signal,
  input wire logic inject_hard_err,
  input wire logic [DATA_W-1:0] other_wb_data,
  input wire logic [3:0] peek_index,
  output logic [DATA_W-1:0] peek_data,
  output logic defer_withheld
);
  logic [DATA_W-1:0] mem_r [16];
  logic [2:0] arb_cnt_r;
  logic grant_r;
  logic lock_seen_r;
  logic busy_r;
  logic [2:0] cyc_r;
  logic write_r;
  logic [3:0] index_r;
  logic [DATA_W-1:0] wdata_r;
  logic address_error_signal_r;
  logic defer_r;
  logic modified_hit_signal_r;
  logic hard_r;
  logic snoop_hit_r;
  logic [DATA_W-1:0] wb_r;
  logic [2:0] resp_code_nxt;

  // ---------------------------------------------------------------
  // arbitration: a locked retry is granted two clocks sooner
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset || !bus.bus_request_line)
    begin
      arb_cnt_r <= 3'h0;
      grant_r <= 1'b0;
    end
    else
    begin
      if (arb_cnt_r != ARB_NORM_CLKS)
        arb_cnt_r <= arb_cnt_r + 3'h1;
      if (bus.priority_arb ? arb_cnt_r >= (ARB_NORM_CLKS - ARB_LEAD_CLKS)
                           : arb_cnt_r == ARB_NORM_CLKS)
        grant_r <= 1'b1;
    end
  end
  assign bus.bus_grant = grant_r;

  // ---------------------------------------------------------------
  // request capture; a transaction is first when the lock line rises with it
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      lock_seen_r <= 1'b0;
    else
      lock_seen_r <= bus.bus_lock_line;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      write_r <= 1'b0;
      index_r <= 4'h0;
      address_error_signal_r <= 1'b0;
      defer_r <= 1'b0;
      modified_hit_signal_r <= 1'b0;
      hard_r <= 1'b0;
      defer_withheld <= 1'b0;
    end
    else
    begin
      defer_withheld <= 1'b0;
      if (bus.req_valid)
      begin
        write_r <= bus.req_write;
        index_r <= bus.req_addr[6:3];
        address_error_signal_r <= inject_address_error_signal;
        hard_r <= inject_hard_err;
        modified_hit_signal_r <= inject_modified_hit_signal && !bus.req_write;
        // later locked transactions must never be deferred
        defer_r <= inject_defer && (!bus.bus_lock_line || !lock_seen_r);
        defer_withheld <= inject_defer && bus.bus_lock_line && lock_seen_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // phase counter for the single outstanding transaction
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      cyc_r <= 3'h0;
      wdata_r <= '0;
    end
    else if (bus.req_phase2)
    begin
      busy_r <= 1'b1;
      cyc_r <= 3'h0;
      wdata_r <= bus.wdata;
    end
    else if (busy_r)
    begin
      cyc_r <= cyc_r + 3'h1;
      // an address error kills the transaction before its snoop phase
      if ((cyc_r == ERR_AT && address_error_signal_r) || cyc_r == RESP_AT)
        busy_r <= 1'b0;
    end
  end

  assign bus.address_error_signal = busy_r && cyc_r == ERR_AT && address_error_signal_r;
  assign bus.defer_snoop_signal = busy_r && cyc_r == SNOOP_AT && defer_r;
  assign bus.hit_others = busy_r && cyc_r == SNOOP_AT && modified_hit_signal_r;

  // snoop result and the modified line that comes with it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      snoop_hit_r <= 1'b0;
      wb_r <= '0;
    end
    else if (busy_r && cyc_r == SNOOP_AT)
    begin
      snoop_hit_r <= bus.modified_hit_signal;
      wb_r <= modified_hit_signal_r ? other_wb_data : bus.wb_data;
    end
  end

  // ---------------------------------------------------------------
  // response: modified hit overrides defer, defer alone means retry
  // ---------------------------------------------------------------
  always_comb
  begin
    if (snoop_hit_r)
      resp_code_nxt = RESP_IMPL_WB;
    else if (defer_r)
      resp_code_nxt = RESP_RETRY;
    else if (hard_r)
      resp_code_nxt = RESP_HARD_ERR;
    else
      resp_code_nxt = RESP_NORMAL;
  end

  assign bus.resp_valid = busy_r && cyc_r == RESP_AT;
  assign bus.resp_code = resp_code_nxt;
  assign bus.rdata = snoop_hit_r ? wb_r : mem_r[index_r];

  // memory takes writes and implicit writebacks, never retried data
  always_ff @(posedge clk)
  begin
    if (bus.resp_valid && resp_code_nxt == RESP_NORMAL && write_r)
      mem_r[index_r] <= wdata_r;
    else if (bus.resp_valid && resp_code_nxt == RESP_IMPL_WB)
      mem_r[index_r] <= wb_r;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      peek_data <= '0;
    else
      peek_data <= mem_r[peek_index];
  end
endmodule
`default_nettype wire

// >>> rtl/lock_issuer.sv
// issuing agent: chooses cache lock or bus lock and sequences the locked exchange
//
// Added by the designer: the strobed register access.
`default_nettype none
module lock_issuer
  import lock_pkg::*;
#(
  parameter int RETRY_LIMIT = RETRY_LIMIT_DEF
)
(
  input wire logic clk,
  input wire logic reset,
  lock_bus_if.issuer bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [3:0] cmd_size,
  input wire logic [2*DATA_W-1:0] cmd_wdata,
  input wire logic line_owned,
  input wire logic line_modified,
  input wire logic [DATA_W-1:0] line_data,
  input wire logic mt_wr,
  input wire logic [MT_W-1:0] mt_wr_data,
  output logic [MT_W-1:0] memory_type_range_reg,
  output logic gp_fault,
  output logic cacheable,
  output logic speculative_ok,
  output logic write_allocate,
  output logic write_to_memory,
  output logic write_combine,
  output logic cache_rmw_go,
  output logic done,
  output logic fail,
  output logic [2*DATA_W-1:0] result_data
);
  // elaboration check: the retry counter is only four bits wide
  if (RETRY_LIMIT < 1 || RETRY_LIMIT > 15)
  begin : bad_retry_limit
    $error("RETRY_LIMIT must lie in 1..15");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_REQ1, S_REQ2, S_WAIT, S_ABORT, S_CACHE, S_DONE, S_FAIL
  } state_e;

  state_e state_r;
  logic [1:0] tx_idx_r;
  logic [1:0] tx_last_r;
  logic fill_r;
  logic split_r;
  logic prio_r;
  logic lock_r;
  logic [3:0] retry_cnt_r;
  logic [2:0] cyc_r;
  logic defer_seen_r;
  logic self_mod_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2*DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wb_r;
  logic crosses;
  logic cache_ok;
  logic is_write;
  logic [ADDR_W-1:0] tx_addr;
  logic hi_half;

  // ---------------------------------------------------------------
  // memory-type range register and its policy decode
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      memory_type_range_reg <= MT_RESET;
      gp_fault <= 1'b0;
    end
    else
    begin
      gp_fault <= 1'b0;
      if (mt_wr)
      begin
        unique case (mt_wr_data)
          MT_UNCACHED, MT_COMBINING_WRITE, MT_WRITE_THROUGH, MT_PROTECTED_WRITE, MT_WRITEBACK:
            memory_type_range_reg <= mt_wr_data;
          default:
            gp_fault <= 1'b1;
        endcase
      end
    end
  end

  // policy flags that the core and cache obey for the current type
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cacheable <= 1'b0;
      speculative_ok <= 1'b0;
      write_allocate <= 1'b0;
      write_to_memory <= 1'b1;
      write_combine <= 1'b0;
    end
    else
    begin
      cacheable <= memory_type_range_reg inside {MT_WRITE_THROUGH, MT_PROTECTED_WRITE,
                                                 MT_WRITEBACK};
      speculative_ok <= memory_type_range_reg != MT_UNCACHED;
      write_allocate <= memory_type_range_reg == MT_WRITEBACK;
      write_to_memory <= memory_type_range_reg != MT_WRITEBACK;
      write_combine <= memory_type_range_reg == MT_COMBINING_WRITE;
    end
  end

  // ---------------------------------------------------------------
  // lock strategy: only writeback data that stays in one 8-byte span
  // ---------------------------------------------------------------
  assign crosses = ({1'b0, cmd_addr[2:0]} + cmd_size) > LOCK_SPAN_BYTES;
  assign cache_ok = memory_type_range_reg == MT_WRITEBACK && !crosses;
  assign is_write = tx_idx_r > (tx_last_r >> 1);
  // only a split sequence touches the second word; a plain one stays on one address
  assign hi_half = split_r && tx_idx_r[0];
  assign tx_addr = {addr_r[ADDR_W-1:3], 3'h0} + {{(ADDR_W-4){1'b0}}, hi_half, 3'h0};

  // ---------------------------------------------------------------
  // bus drive; everything comes from sequencer registers, and the attribute code from the range register
  // ---------------------------------------------------------------
  assign cmd_ready = state_r == S_IDLE;
  assign bus.bus_request_line = state_r == S_ARB;
  assign bus.priority_arb = state_r == S_ARB && prio_r;
  assign bus.req_valid = state_r == S_REQ1;
  assign bus.req_phase2 = state_r == S_REQ2;
  assign bus.req_write = is_write && !fill_r;
  assign bus.req_addr = tx_addr;
  assign bus.attribute_lines = state_r == S_REQ2 ? memory_type_range_reg : '0;
  assign bus.wdata = hi_half ? wdata_r[2*DATA_W-1:DATA_W] : wdata_r[DATA_W-1:0];
  // the line falls as soon as the sequence ends or aborts, not a cycle later
  assign bus.bus_lock_line = lock_r && !(state_r inside {S_ABORT, S_DONE, S_FAIL});
  assign bus.split_lock_flag = split_r && tx_idx_r == 2'h0 && lock_r &&
                               (state_r == S_REQ1 || state_r == S_REQ2);
  // no deferred-reply tracking here, so nothing is ever offered for deferral
  assign bus.defer_enable_flag = 1'b0;
  assign bus.hit_issuer = state_r == S_WAIT && cyc_r == SNOOP_AT && self_mod_r &&
                          !fill_r && tx_idx_r == 2'h0;
  assign bus.wb_data = wb_r;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= S_IDLE;
      tx_idx_r <= 2'h0;
      tx_last_r <= 2'h0;
      fill_r <= 1'b0;
      split_r <= 1'b0;
      prio_r <= 1'b0;
      lock_r <= 1'b0;
      retry_cnt_r <= 4'h0;
      cyc_r <= 3'h0;
      defer_seen_r <= 1'b0;
      self_mod_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      wb_r <= '0;
      result_data <= '0;
      cache_rmw_go <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      cache_rmw_go <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      unique case (state_r)
        S_IDLE:
          if (cmd_valid)
          begin
            addr_r <= cmd_addr;
            wdata_r <= cmd_wdata;
            wb_r <= line_data;
            self_mod_r <= line_modified;
            split_r <= crosses;
            tx_last_r <= crosses ? 2'h3 : 2'h1;
            tx_idx_r <= 2'h0;
            retry_cnt_r <= 4'h0;
            prio_r <= 1'b0;
            fill_r <= cache_ok && !line_owned;
            if (cache_ok && line_owned)
              state_r <= S_CACHE;
            else
              state_r <= S_ARB;
          end
        S_ARB:
          if (bus.bus_grant)
          begin
            state_r <= S_REQ1;
            prio_r <= 1'b0;
            if (!fill_r)
              lock_r <= 1'b1;
          end
        S_REQ1:
          state_r <= S_REQ2;
        S_REQ2:
        begin
          state_r <= S_WAIT;
          cyc_r <= 3'h0;
          defer_seen_r <= 1'b0;
        end
        S_WAIT:
        begin
          cyc_r <= cyc_r + 3'h1;
          if (cyc_r == ERR_AT && bus.address_error_signal)
          begin
            if (retry_cnt_r == 4'(RETRY_LIMIT))
              state_r <= S_FAIL;
            else
            begin
              retry_cnt_r <= retry_cnt_r + 4'h1;
              if (tx_idx_r == 2'h0 || fill_r)
                state_r <= S_ABORT;
              else
              begin
                prio_r <= 1'b1;
                state_r <= S_ARB;
              end
            end
          end
          else if (cyc_r == SNOOP_AT)
          begin
            defer_seen_r <= bus.defer_snoop_signal && !bus.modified_hit_signal;
            if (bus.defer_snoop_signal && tx_idx_r != 2'h0 && !fill_r)
              state_r <= S_FAIL;
            else if (bus.defer_snoop_signal)
              defer_seen_r <= 1'b1;
          end
          else if (bus.resp_valid)
          begin
            if (defer_seen_r)
              state_r <= S_ABORT;
            else if (bus.resp_code == RESP_HARD_ERR || bus.resp_code == RESP_DEFERRED)
              state_r <= S_FAIL;
            else if (bus.resp_code == RESP_RETRY)
              state_r <= fill_r ? S_ARB : S_FAIL;
            else if (fill_r)
              state_r <= S_CACHE;
            else
            begin
              if (!is_write)
              begin
                // modified lines arrive here through the implicit writeback
                if (tx_idx_r[0])
                  result_data[2*DATA_W-1:DATA_W] <= bus.rdata;
                else
                  result_data[DATA_W-1:0] <= bus.rdata;
              end
              if (tx_idx_r == tx_last_r)
                state_r <= S_DONE;
              else
              begin
                tx_idx_r <= tx_idx_r + 2'h1;
                state_r <= S_REQ1;
              end
            end
          end
        end
        S_ABORT:
        begin
          // read data already captured is simply overwritten on reissue
          lock_r <= 1'b0;
          tx_idx_r <= 2'h0;
          state_r <= S_ARB;
        end
        S_CACHE:
        begin
          cache_rmw_go <= 1'b1;
          state_r <= S_DONE;
        end
        S_DONE:
        begin
          lock_r <= 1'b0;
          done <= 1'b1;
          state_r <= S_IDLE;
        end
        S_FAIL:
        begin
          lock_r <= 1'b0;
          fail <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/lock_rmw_props.sv
// assertion checker watching the shared locked-sequence bus
`default_nettype none
module lock_rmw_props
  import lock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_request_line,
  input wire logic priority_arb,
  input wire logic bus_grant,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic bus_lock_line,
  input wire logic split_lock_flag,
  input wire logic defer_enable_flag,
  input wire logic address_error_signal,
  input wire logic defer_snoop_signal,
  input wire logic modified_hit_signal,
  input wire logic resp_valid,
  input wire logic [2:0] resp_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----
  // requests under the current lock; restarts when the lock drops
  // ----
  logic [3:0] ntx_r;
  always_ff @(posedge clk)
  begin
    if (reset || !bus_lock_line)
      ntx_r <= 4'h0;
    else if (req_valid && ntx_r != 4'hf)
      ntx_r <= ntx_r + 4'h1;
  end
  chk_den_locked: assert property (bus_lock_line && req_valid |-> !defer_enable_flag)
    else $error("defer enable on a locked request");
  chk_lock_rise: assert property ($rose(bus_lock_line) |-> req_valid && !req_write)
    else $error("lock raised off a first read");
  chk_lock_fall: assert property ($fell(bus_lock_line) |-> $past(resp_valid)
    || $past(address_error_signal) || $past(address_error_signal, 2))
    else $error("lock dropped mid transaction");
  chk_split_first: assert property (split_lock_flag |-> bus_lock_line && ntx_r < 4'h2)
    else $error("split flag off the first request");
  chk_defer_first: assert property (defer_snoop_signal && bus_lock_line |-> ntx_r == 4'h1)
    else $error("defer on a later locked request");
  chk_retry_resp: assert property (defer_snoop_signal && !modified_hit_signal
    |=> resp_valid && resp_code == RESP_RETRY)
    else $error("defer not answered by retry");
  chk_impl_wb: assert property (defer_snoop_signal && modified_hit_signal
    |=> resp_valid && resp_code == RESP_IMPL_WB)
    else $error("modified hit not answered by writeback");
  chk_abort_drop: assert property (defer_snoop_signal && bus_lock_line ##1 resp_valid
    |=> !bus_lock_line && !bus_request_line)
    else $error("lock or request kept after abort");
  chk_prio_grant: assert property ($rose(bus_request_line) && priority_arb |-> ##2 bus_grant)
    else $error("priority request not granted early");
  chk_norm_grant: assert property ($rose(bus_request_line) && !priority_arb |-> ##4 bus_grant)
    else $error("request not granted in time");
endmodule
`default_nettype wire

// >>> tb/locked_rmw_bus_sequencer_test.sv
// self-checking bench: issuer and other agents joined on the lock bus
`default_nettype none
module locked_rmw_bus_sequencer_test
  import lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic line_owned = 1'b0;
  logic line_modified = 1'b0;
  logic mt_wr = 1'b0;
  logic cmd_ready, gp_fault, cacheable, speculative_ok, write_allocate, write_to_memory;
  logic write_combine, cache_rmw_go, done, fail, defer_withheld, spl, wh;
  logic [35:0] cmd_addr = 36'h0;
  logic [3:0] cmd_size = 4'h1;
  logic [127:0] cmd_wdata = 128'h0;
  logic [127:0] result_data;
  logic [7:0] mt_wr_data = 8'h00;
  logic [7:0] cur_mt = 8'h00;
  logic [7:0] memory_type_range_reg;
  logic [63:0] line_data = 64'h1111_2222_3333_4444;
  logic [63:0] other_wb_data = 64'h5555_6666_7777_8888;
  logic [31:0] plan = 32'h0;
  logic [2:0] ntx = 3'h0;
  logic [2:0] base = 3'h0;
  logic [2:0] txi;
  logic [3:0] peek_ix = 4'h0;
  logic [63:0] peek_data;
  logic [36:0] log_q[$];
  logic [63:0] mem_e[16];
  bit known[16];
  logic [21:0] rows[7] = '{{8'h00, 8'h00, 6'h02}, {8'h04, 8'h04, 6'h0b}, {8'h05, 8'h05, 6'h1a},
    {8'h06, 8'h06, 6'h1a}, {8'h07, 8'h07, 6'h1c}, {8'h03, 8'h07, 6'h3c}, {8'hff, 8'h07, 6'h3c}};
  int mismatches = 0;
  int num_checks = 0;
  int lat, gl;
  int k = 0;
  // fault plan bytes: defer, address error, modified hit, hard error, one bit per request
  assign txi = ntx - base;
  lock_bus_if bus();
  lock_issuer #(.RETRY_LIMIT(LIM)) i_lock_issuer (.clk, .reset, .bus(bus), .cmd_valid,
    .cmd_ready, .cmd_addr, .cmd_size, .cmd_wdata, .line_owned, .line_modified, .line_data,
    .mt_wr, .mt_wr_data, .memory_type_range_reg, .gp_fault, .cacheable, .speculative_ok,
    .write_allocate, .write_to_memory, .write_combine, .cache_rmw_go, .done, .fail,
    .result_data);
  lock_others i_lock_others (.clk, .reset, .bus(bus), .inject_address_error_signal(plan[{2'h2, txi}]),
    .inject_defer(plan[{2'h3, txi}]), .inject_modified_hit_signal(plan[{2'h1, txi}]),
    .inject_hard_err(plan[{2'h0, txi}]), .other_wb_data, .peek_index(peek_ix), .peek_data,
    .defer_withheld);
  lock_rmw_props i_lock_rmw_props (.clk, .reset, .bus_request_line(bus.bus_request_line),
    .priority_arb(bus.priority_arb), .bus_grant(bus.bus_grant), .req_valid(bus.req_valid),
    .req_write(bus.req_write), .bus_lock_line(bus.bus_lock_line),
    .split_lock_flag(bus.split_lock_flag), .defer_enable_flag(bus.defer_enable_flag),
    .address_error_signal(bus.address_error_signal),
    .defer_snoop_signal(bus.defer_snoop_signal), .modified_hit_signal(bus.modified_hit_signal),
    .resp_valid(bus.resp_valid), .resp_code(bus.resp_code));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bus monitor: logs every request and checks its attribute code on the wire
  always @(posedge clk)
  begin
    if (bus.req_valid === 1'b1)
    begin
      ntx <= ntx + 3'h1;
      log_q.push_back({bus.req_write, bus.req_addr});
    end
    if (bus.req_phase2 === 1'b1)
      chk("attr", bus.attribute_lines, cur_mt);
    if (bus.split_lock_flag === 1'b1)
      spl = 1'b1;
    if (defer_withheld === 1'b1)
      wh = 1'b1;
  end
  task automatic mtw(input logic [7:0] code, input logic [7:0] ereg, input logic [5:0] ef);
    @(posedge clk);
    mt_wr <= 1'b1;
    mt_wr_data <= code;
    cur_mt <= ereg;
    @(posedge clk);
    mt_wr <= 1'b0;
    #1;
    chk("range", {gp_fault, memory_type_range_reg}, {ef[5], ereg});
    @(posedge clk);
    #1;
    chk("decode", {cacheable, speculative_ok, write_allocate, write_to_memory, write_combine},
      ef[4:0]);
  endtask
  // one locked exchange; pl holds the fault plan, m is {owned, modified}
  task automatic lk(input logic [35:0] a, input logic [3:0] sz, input logic [7:0] mt,
      input logic [1:0] m, input logic [31:0] pl, input logic [2:0] n, input logic ef);
    logic sp;
    logic [3:0] ix;
    logic [63:0] e0;
    logic [5:0] efm;
    sp = ({1'b0, a[2:0]} + sz) > 4'h8;
    ix = a[6:3];
    e0 = m[0] ? line_data : (pl[8] ? other_wb_data : mem_e[ix]);
    k++;
    // expected policy flags of this type come from the table rows
    efm = 6'h00;
    foreach (rows[i])
      if (rows[i][21:14] == mt)
        efm = rows[i][5:0];
    mtw(mt, mt, efm);
    @(posedge clk);
    plan <= pl;
    base <= ntx;
    {line_owned, line_modified} <= m;
    cmd_addr <= a;
    cmd_size <= sz;
    cmd_wdata <= {k + 1, k + 1, k, k};
    cmd_valid <= 1'b1;
    spl = 1'b0;
    wh = 1'b0;
    log_q.delete();
    @(posedge clk);
    cmd_valid <= 1'b0;
    lat = 0;
    gl = 0;
    while (done !== 1'b1 && fail !== 1'b1 && lat < 600)
    begin
      @(posedge clk);
      #1;
      lat++;
      if (cache_rmw_go === 1'b1)
        gl = lat;
    end
    chk("end", {done, fail}, {!ef, ef});
    chk("txns", txi, n);
    chk("late_defer", wh, |pl[31:25]);
    if (!ef && n > 3'h1 && pl[31:16] == 16'h0000)
    begin
      chk("split", spl, sp);
      for (int i = 0; i < n; i++)
        chk("seq", log_q[i], {1'(i >= n / 2), {a[35:3], 3'h0} + 36'(8 * (i % (n / 2)))});
      if (known[ix] || m[0] || pl[8])
        chk("rd_lo", result_data[63:0], e0);
      if (sp && known[ix + 1])
        chk("rd_hi", result_data[127:64], mem_e[ix + 1]);
    end
    if (!ef && n > 3'h1)
    begin
      {mem_e[ix + 1], mem_e[ix]} = cmd_wdata;
      known[ix] = 1'b1;
      known[ix + 1] = sp | known[ix + 1];
      // the locked write must have landed at the lock address
      @(posedge clk);
      peek_ix <= ix;
      @(posedge clk);
      #1;
      chk("mem", peek_data, mem_e[ix]);
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst", {memory_type_range_reg, cacheable, speculative_ok, write_allocate,
      write_to_memory, write_combine}, {MT_RESET, 5'h02});
    chk("rst_bus", {cmd_ready, bus.bus_lock_line, bus.bus_request_line}, 3'h4);
    foreach (rows[i])
      mtw(rows[i][21:14], rows[i][13:6], rows[i][5:0]);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b10, 32'h0, 3'h2, 1'b0);
    lk(36'h104, 4'h4, MT_COMBINING_WRITE, 2'b00, 32'h0, 3'h2, 1'b0);
    lk(36'h10c, 4'h8, MT_WRITE_THROUGH, 2'b00, 32'h0, 3'h4, 1'b0);
    lk(36'h10c, 4'h8, MT_WRITEBACK, 2'b11, 32'h0, 3'h4, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0100_0000, 3'h3, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0100_0100, 3'h3, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0000_0100, 3'h2, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0002_0000, 3'h3, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0001_0000, 3'h3, 1'b0);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h00ff_0000, 3'h3, 1'b1);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0000_0001, 3'h1, 1'b1);
    lk(36'h100, 4'h4, MT_UNCACHED, 2'b00, 32'h0200_0000, 3'h2, 1'b0);
    lk(36'h148, 4'h4, MT_WRITEBACK, 2'b00, 32'h0, 3'h1, 1'b0);
    chk("fill_go", gl != 0, 1'b1);
    lk(36'h140, 4'h4, MT_WRITEBACK, 2'b10, 32'h0, 3'h0, 1'b0);
    chk("cache_lat", {gl, lat}, {32'h1, 32'h2});
    give_verdict();
  end
  // watchdog: generous bound for about fifteen exchanges
  initial
  begin
    #300000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
